// [core/ohm_cmd_pkg.sv]
`default_nettype none
package ohm_cmd_pkg;
    // Character codes used on the bus
    localparam logic [7:0] ASC_CR    = 8'h0D;
    localparam logic [7:0] ASC_LF    = 8'h0A;
    localparam logic [7:0] ASC_SPACE = 8'h20;
    localparam logic [7:0] ASC_PLUS  = 8'h2B;
    localparam logic [7:0] ASC_COMMA = 8'h2C;
    localparam logic [7:0] ASC_MINUS = 8'h2D;
    localparam logic [7:0] ASC_DOT   = 8'h2E;
    localparam logic [7:0] ASC_0     = 8'h30;
    localparam logic [7:0] ASC_9     = 8'h39;
    // Command and status letters
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_C = 8'h43;
    localparam logic [7:0] CH_D = 8'h44;
    localparam logic [7:0] CH_E = 8'h45;
    localparam logic [7:0] CH_F = 8'h46;
    localparam logic [7:0] CH_H = 8'h48;
    localparam logic [7:0] CH_I = 8'h49;
    localparam logic [7:0] CH_L = 8'h4C;
    localparam logic [7:0] CH_N = 8'h4E;
    localparam logic [7:0] CH_Q = 8'h51;
    localparam logic [7:0] CH_S = 8'h53;
    localparam logic [7:0] CH_T = 8'h54;
    localparam logic [7:0] CH_U = 8'h55;
    localparam logic [7:0] CH_V = 8'h56;
    // Any poll answer other than ASCII zero will do; this one is arbitrary
    localparam logic [7:0] SPOLL_ACTIVE = 8'h41;
    // Highest legal argument digit per command
    localparam logic [3:0] MAX_VOLT = 4'h2;
    localparam logic [3:0] MAX_CUR  = 4'h5;
    localparam logic [3:0] MAX_BIT  = 4'h1;
    localparam logic [3:0] MAX_TERM = 4'h3;
    // Terminator code bits: bit0 adds EOI, bit1 drops the LF
    localparam int TERM_EOI     = 0;
    localparam int TERM_CR_ONLY = 1;
    // Message lengths without terminator
    localparam logic [4:0] RD_LEN = 5'h0A;
    localparam logic [4:0] ST_LEN = 5'h0F;
    localparam logic [19:0] OVR_MANT = 20'h20000;
    // Register port map
    localparam logic [1:0] REG_CFG   = 2'h0;
    localparam logic [1:0] REG_COND  = 2'h1;
    localparam logic [1:0] REG_STATE = 2'h2;

    typedef enum logic [2:0] {
        PS_CMD  = 3'b001,
        PS_ARG  = 3'b010,
        PS_SKIP = 3'b100
    } parse_e;

    typedef struct packed {
        logic            neg;
        logic            ovr;
        logic [4:0][3:0] mant;
        logic            exp_neg;
        logic [3:0]      exp;
    } reading_s;

    typedef struct packed {
        logic       q_en;
        logic [1:0] volt;
        logic [2:0] cur;
        logic       hold;
        logic       comp;
        logic [1:0] term;
        logic       src;
    } settings_s;

    typedef struct packed {
        logic unsafe;
        logic charging;
        logic comp_fault;
    } cond_s;

    localparam settings_s CFG_RESET = '0;
endpackage
`default_nettype wire

// [core/ohm_cmd_parser.sv]
// Functional notes
// RULE1: Latest displayed reading always readable, even in local; reading it empties buffer.
// RULE2: Controller waits for next conversion before fresh value; 2.5 readings per second.
// RULE3: Readings sent as signed scientific ASCII; over-range shows +2.0000 mantissa.
// RULE4: Every outgoing message ends with selected terminator, CR LF after reset.
// RULE5: D0 CR LF, D1 CR LF with EOI, D2 CR, D3 CR with EOI.
// RULE6: Same terminator for readings and the status word.
// RULE7: Command line ends on CR or on EOI with last byte.
// RULE8: Controller sends upper case; several commands separated by commas.
// RULE9: V0 20mV, V1 200mV, V2 2V voltmeter range.
// RULE10: I0 to I5 select 0.1mA up to 10A test current.
// RULE11: C0 turns source off, C1 turns it on.
// RULE12: Q0 keeps SRQ low (default); Q1 raises SRQ on undecodable command.
// RULE13: Serial poll answers ASCII zero unless this device raised SRQ.
// RULE14: Tracking by default: every conversion updates display and buffer; T restores.
// RULE15: Hold stops updates; each further S loads one latest result.
// RULE16: N turns temperature compensation off, A turns it on.
// RULE17: E loads status word; readings withheld until it has been read.
// RULE18: Status word echoes Q, V, I, S/T, N/A, D and C settings in order.
// RULE19: Last three status chars U, H, F, each a space when condition absent.
// RULE20: L command returns device to local state.
// RULE21: Own listen address with REN asserted enters remote state.
// RULE22: Commands ignored in local state; readings still retrievable.
// RULE23: Undecodable command changes nothing; SRQ only when requests enabled.
`timescale 1ns/1ps
`default_nettype none
module ohm_cmd_parser
    import ohm_cmd_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       ren,
    input  wire logic       listen_addr,
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_eoi,
    input  wire logic       tx_ready,
    output logic            tx_valid,
    output logic [7:0]      tx_data,
    output logic            tx_eoi,
    input  wire logic       spoll,
    output logic            srq,
    output logic [7:0]      spoll_byte,
    input  wire logic       conv_valid,
    input  wire reading_s   conv_data,
    output reading_s        display,
    output settings_s       cfg,
    output logic            remote,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata
);
    parse_e      pstate;
    parse_e      next_pstate;
    settings_s   next_cfg;
    logic [7:0]  arg_cmd;
    logic [3:0]  arg_max;
    reading_s    latest;
    logic        rd_pend;
    logic        stat_pend;
    logic        buf_full;
    logic        buf_stat;
    reading_s    snap_rd;
    settings_s   snap_cfg;
    cond_s       snap_cond;
    cond_s       cond;
    logic [4:0]  idx;
    logic [7:0]  cur_char;
    logic [7:0]  rd_mux;

    function automatic logic [7:0] asc(input logic [3:0] d);
        return ASC_0 + {4'h0, d};
    endfunction

    // Byte decode; the bus side is ignored while local
    // RULE22: local ignores commands
    wire logic       take      = rx_valid && remote;
    wire logic       is_cr     = rx_data == ASC_CR;
    wire logic       is_comma  = rx_data == ASC_COMMA;
    wire logic       is_dig    = rx_data >= ASC_0 && rx_data <= ASC_9;
    wire logic [3:0] dig       = rx_data[3:0];
    wire logic       needs_arg = rx_data inside {CH_V, CH_I, CH_Q, CH_D, CH_C};
    wire logic       is_imm    = rx_data inside {CH_S, CH_T, CH_N, CH_A, CH_L, CH_E};
    // RULE7: line end detect
    wire logic       line_end  = take && (is_cr || rx_eoi);
    wire logic       in_cmd    = take && pstate == PS_CMD && !is_cr;
    wire logic       in_arg    = take && pstate == PS_ARG;
    wire logic       arg_ok    = is_dig && dig <= arg_max;
    wire logic       exec_imm  = in_cmd && is_imm;
    wire logic       exec_arg  = in_arg && arg_ok;
    // RULE23: undecodable input
    wire logic       bad       = (in_cmd && !is_imm && !needs_arg && !is_comma)
                               || (in_cmd && needs_arg && rx_eoi)
                               || (in_arg && !arg_ok);
    wire logic       cmd_hold  = exec_imm && rx_data == CH_S;
    wire logic       cmd_track = exec_imm && rx_data == CH_T;
    wire logic       cmd_norm  = exec_imm && rx_data == CH_N;
    wire logic       cmd_comp  = exec_imm && rx_data == CH_A;
    wire logic       cmd_local = exec_imm && rx_data == CH_L;
    wire logic       cmd_query = exec_imm && rx_data == CH_E;
    // RULE15: trigger while holding
    wire logic       trig      = cmd_hold && cfg.hold;
    // RULE14: tracking updates
    wire logic       upd_disp  = (conv_valid && !cfg.hold) || trig;
    wire logic       q_clear   = exec_arg && arg_cmd == CH_Q && dig == 4'h0;
    wire logic       srq_set   = bad && cfg.q_en;

    always_comb
    begin
        case (arg_cmd)
            CH_V:    arg_max = MAX_VOLT;
            CH_I:    arg_max = MAX_CUR;
            CH_D:    arg_max = MAX_TERM;
            CH_Q,
            CH_C:    arg_max = MAX_BIT;
            default: arg_max = 4'h0;
        endcase
    end

    always_comb
    begin
        next_pstate = pstate;
        if (take)
        begin
            if (line_end)
                next_pstate = PS_CMD;
            else if (bad)
                next_pstate = PS_SKIP;
            else if (pstate == PS_CMD && needs_arg)
                next_pstate = PS_ARG;
            else if (pstate == PS_ARG)
                next_pstate = PS_CMD;
            else if (pstate == PS_SKIP && is_comma)
                next_pstate = PS_CMD;
        end
    end

    always_comb
    begin
        next_cfg = cfg;
        if (exec_arg)
        begin
            case (arg_cmd)
                // RULE9: voltage range
                CH_V:    next_cfg.volt = dig[1:0];
                // RULE10: current range
                CH_I:    next_cfg.cur = dig[2:0];
                // RULE12: request enable
                CH_Q:    next_cfg.q_en = dig[0];
                // RULE5: terminator select
                CH_D:    next_cfg.term = dig[1:0];
                // RULE11: source switch
                CH_C:    next_cfg.src = dig[0];
                default: next_cfg = cfg;
            endcase
        end
        // RULE15: hold and track
        if (cmd_hold)
            next_cfg.hold = 1'b1;
        if (cmd_track)
            next_cfg.hold = 1'b0;
        // RULE16: compensation on and off
        if (cmd_norm)
            next_cfg.comp = 1'b0;
        if (cmd_comp)
            next_cfg.comp = 1'b1;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pstate  <= PS_CMD;
            arg_cmd <= 8'h00;
            cfg     <= CFG_RESET;
        end
        else
        begin
            pstate <= remote ? next_pstate : PS_CMD;
            cfg    <= next_cfg;
            if (in_cmd && needs_arg)
                arg_cmd <= rx_data;
        end
    end

    // RULE21: enter remote
    // RULE20: back to local
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            remote <= 1'b0;
        else if (listen_addr && ren)
            remote <= 1'b1;
        else if (!ren || cmd_local)
            remote <= 1'b0;
    end

    // RULE12: request raised, set wins over poll
    // RULE13: poll answer
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            srq        <= 1'b0;
            spoll_byte <= ASC_0;
        end
        else
        begin
            srq        <= srq_set || (srq && !spoll && !q_clear);
            spoll_byte <= srq ? SPOLL_ACTIVE : ASC_0;
        end
    end

    // Latest result is kept even in hold so a trigger shows it at once
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            latest  <= '0;
            display <= '0;
        end
        else
        begin
            if (conv_valid)
                latest <= conv_data;
            if (upd_disp)
                display <= trig ? latest : conv_data;
        end
    end

    // Status word takes priority; readings wait until it has gone out
    // RULE17: reading withheld
    wire logic load_st = stat_pend && !buf_full;
    wire logic load_rd = rd_pend && !stat_pend && !buf_full;
    wire logic adv     = buf_full && (!tx_valid || tx_ready);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_pend   <= 1'b0;
            stat_pend <= 1'b0;
        end
        else
        begin
            rd_pend   <= upd_disp || (rd_pend && !load_rd);
            stat_pend <= cmd_query || (stat_pend && !load_st);
        end
    end

    // Snapshot taken at load so a setting change cannot tear a message
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_stat  <= 1'b0;
            snap_rd   <= '0;
            snap_cfg  <= CFG_RESET;
            snap_cond <= '0;
        end
        else if (load_st || load_rd)
        begin
            buf_stat  <= load_st;
            snap_rd   <= display;
            snap_cfg  <= cfg;
            snap_cond <= cond;
        end
    end

    // Message text, element 0 is sent first
    // RULE3: scientific text and over-range
    wire logic [4:0][3:0] mant = snap_rd.ovr ? OVR_MANT : snap_rd.mant;
    wire logic [7:0] sgn  = (snap_rd.neg && !snap_rd.ovr) ? ASC_MINUS : ASC_PLUS;
    wire logic [7:0] esgn = snap_rd.exp_neg ? ASC_MINUS : ASC_PLUS;
    wire logic [9:0][7:0] rd_txt = {asc(snap_rd.exp), esgn, CH_E,
                                    asc(mant[0]), asc(mant[1]), asc(mant[2]),
                                    asc(mant[3]), ASC_DOT, asc(mant[4]), sgn};
    // RULE18: status word order
    // RULE19: condition letters
    wire logic [15:0][7:0] st_txt = {
        ASC_SPACE,
        snap_cond.comp_fault ? CH_F : ASC_SPACE,
        snap_cond.charging ? CH_H : ASC_SPACE,
        snap_cond.unsafe ? CH_U : ASC_SPACE,
        asc({3'h0, snap_cfg.src}), CH_C,
        asc({2'h0, snap_cfg.term}), CH_D,
        snap_cfg.comp ? CH_A : CH_N,
        snap_cfg.hold ? CH_S : CH_T,
        asc({1'h0, snap_cfg.cur}), CH_I,
        asc({2'h0, snap_cfg.volt}), CH_V,
        asc({3'h0, snap_cfg.q_en}), CH_Q};
    wire logic [15:0][7:0] txt = buf_stat ? st_txt : {{6{ASC_SPACE}}, rd_txt};
    // RULE4: terminator appended
    // RULE6: same terminator for both kinds
    wire logic [4:0] body_len = buf_stat ? ST_LEN : RD_LEN;
    wire logic [4:0] last_idx = snap_cfg.term[TERM_CR_ONLY] ? body_len : body_len + 5'h01;
    wire logic       is_last  = idx == last_idx;

    always_comb
    begin
        if (idx < body_len)
            cur_char = txt[idx[3:0]];
        else if (idx == body_len)
            cur_char = ASC_CR;
        else
            cur_char = ASC_LF;
    end

    // RULE1: buffer empties on send
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_full <= 1'b0;
            idx      <= 5'h00;
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            tx_eoi   <= 1'b0;
        end
        else
        begin
            if (load_st || load_rd)
                buf_full <= 1'b1;
            else if (adv && is_last)
                buf_full <= 1'b0;
            if (adv)
            begin
                tx_valid <= 1'b1;
                tx_data  <= cur_char;
                // RULE5: EOI on last byte
                tx_eoi   <= is_last && snap_cfg.term[TERM_EOI];
                idx      <= is_last ? 5'h00 : idx + 5'h01;
            end
            else if (tx_ready)
            begin
                tx_valid <= 1'b0;
                tx_eoi   <= 1'b0;
            end
        end
    end

    // Register port: condition flags come from the instrument firmware
    assign rd_mux = (reg_addr == REG_CFG)   ? {cfg.q_en, cfg.volt, cfg.cur, cfg.term} :
                    (reg_addr == REG_COND)  ? {5'h00, cond} :
                    (reg_addr == REG_STATE) ? {cfg.src, cfg.hold, cfg.comp, remote, srq,
                                               stat_pend, rd_pend, buf_full} :
                                              8'h00;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cond      <= '0;
            reg_rdata <= 8'h00;
        end
        else
        begin
            if (reg_wr && reg_addr == REG_COND)
                cond <= reg_wdata[2:0];
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    chk_remote_entry: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE21
        listen_addr && ren |=> remote)
        else $error("remote not entered on listen address");

    chk_local_ignore: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE22
        !remote && !stat_pend |=> $stable(cfg) && !stat_pend)
        else $error("settings changed while local");

    chk_srq_gated: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE12
        $rose(srq) |-> $past(cfg.q_en) && $past(remote))
        else $error("request raised while disabled");

    chk_poll_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE13
        spoll_byte == ASC_0 |-> !$past(srq))
        else $error("poll zero while requesting");

    // Judged at the offer: a later load may refresh the snapshot while the byte still waits
    chk_term_byte: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE5
        adv && is_last |=> tx_valid && tx_eoi == $past(snap_cfg.term[TERM_EOI])
            && tx_data == ($past(snap_cfg.term[TERM_CR_ONLY]) ? ASC_CR : ASC_LF))
        else $error("bad final terminator byte");

    chk_hold_freeze: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE15
        cfg.hold && !cmd_hold ##1 1'b1 |-> $stable(display))
        else $error("display moved in hold");

    chk_track_update: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE14
        conv_valid && !cfg.hold |=> display == $past(conv_data))
        else $error("tracking missed a conversion");

    chk_volt_cmd: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE9
        exec_arg && arg_cmd == CH_V |=> cfg.volt == $past(dig[1:0]))
        else $error("voltage range not taken");

    chk_status_first: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE17
        stat_pend && !buf_full |=> buf_full && buf_stat)
        else $error("reading overtook status word");

    chk_bad_keeps: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE23
        bad |=> $stable(cfg))
        else $error("bad command changed a setting");
endmodule
`default_nettype wire

// [test/ohm_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ohm_ctrl_model (
    input  wire logic       core_clk,
    input  wire logic       slow,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_eoi,
    output logic            tx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_eoi
);
    logic [8:0] got[$];

    initial
    begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_eoi   = 1'b0;
        tx_ready = 1'b0;
    end

    // Stalls on alternate cycles when slow, as a busy controller would
    always @(posedge core_clk)
    begin
        if (tx_valid && tx_ready)
            got.push_back({tx_eoi, tx_data});
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end

    // line ends with CR or EOI
    task automatic send_line(input string s, input bit eoi_end);
        for (int i = 0; i < s.len(); i++)
        begin
            @(posedge core_clk);
            rx_valid <= 1'b1;
            rx_data  <= s[i];
            rx_eoi   <= eoi_end && (i == s.len() - 1);
        end
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_eoi   <= 1'b0;
        // A released bus shows the inverse, never the stale byte
        rx_data  <= ~rx_data;
    endtask
endmodule
`default_nettype wire

// [test/gpib_ohmmeter_command_parser_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module gpib_ohmmeter_command_parser_tb_top import ohm_cmd_pkg::*;;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       ren = 1'b0;
    logic       listen_addr = 1'b0;
    logic       rx_valid, rx_eoi, tx_ready, slow = 1'b0;
    logic [7:0] rx_data;
    logic       tx_valid, tx_eoi, srq, remote;
    logic [7:0] tx_data, spoll_byte, reg_rdata;
    logic       spoll = 1'b0;
    logic       conv_valid = 1'b0;
    reading_s   conv_data = '0;
    reading_s   display;
    settings_s  cfg;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    int         n_errors = 0;
    int         checked = 0;
    reading_s   rds[4];
    string      rstr[4];
    // Settings left by the remote test: Q1 V1 I3 T N D0 C0
    localparam settings_s CFG_B = settings_s'({1'b1, 2'h1, 3'h3, 1'b0, 1'b0, 2'h0, 1'b0});

    always #20 core_clk = ~core_clk;

    ohm_cmd_parser u_dut (
        .core_clk, .rst_n, .ren, .listen_addr, .rx_valid, .rx_data, .rx_eoi,
        .tx_ready, .tx_valid, .tx_data, .tx_eoi, .spoll, .srq, .spoll_byte,
        .conv_valid, .conv_data, .display, .cfg, .remote,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
    );

    ohm_ctrl_model u_ctrl (
        .core_clk, .slow, .rx_valid, .rx_data, .rx_eoi,
        .tx_ready, .tx_valid, .tx_data, .tx_eoi
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [1:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        check(what, reg_rdata, exp);
    endtask

    task automatic conv(input reading_s r);
        @(posedge core_clk);
        conv_valid <= 1'b1;
        conv_data <= r;
        @(posedge core_clk);
        conv_valid <= 1'b0;
    endtask

    // Compares every byte taken by the controller and their count, EOI only on the last and only when eoi is set
    task automatic expect_msg(input string what, input string s, input bit eoi);
        for (int w = 0; w < 400 && u_ctrl.got.size() < s.len(); w++)
            tick(1);
        tick(4);
        check({what, " count"}, u_ctrl.got.size(), s.len());
        for (int i = 0; i < s.len(); i++)
            check(what, u_ctrl.got[i], {eoi && (i == s.len() - 1), s[i]});
        u_ctrl.got.delete();
    endtask

    task automatic spoll_pulse();
        @(posedge core_clk);
        spoll <= 1'b1;
        @(posedge core_clk);
        spoll <= 1'b0;
        tick(2);
    endtask

    task automatic t_local();
        tick(1);
        check("cfg reset", cfg, CFG_RESET);
        check("remote reset", remote, 0);
        check("poll idle", spoll_byte, 8'h30);
        reg_read(REG_CFG, 8'h00, "cfg reg");
        reg_read(2'h3, 8'h00, "unmapped");
        u_ctrl.send_line("V2\r", 1'b0);
        tick(4);
        check("volt local", cfg.volt, 2'h0);
        conv(rds[0]);
        expect_msg("local reading", {rstr[0], "\r\n"}, 1'b0);
        $display("t_local done");
    endtask

    task automatic t_remote();
        @(posedge core_clk);
        ren <= 1'b1;
        listen_addr <= 1'b1;
        @(posedge core_clk);
        listen_addr <= 1'b0;
        tick(2);
        check("remote", remote, 1);
        u_ctrl.send_line("V2,I5,C1,Q1,A\r", 1'b0);
        tick(3);
        check("cfg a", cfg, {1'b1, 2'h2, 3'h5, 1'b0, 1'b1, 2'h0, 1'b1});
        u_ctrl.send_line("V1,I3,C0,N", 1'b1);
        tick(3);
        check("cfg b", cfg, CFG_B);
        reg_read(REG_CFG, 8'hAC, "cfg reg");
        $display("t_remote done");
    endtask

    task automatic t_term();
        string ex;
        for (int d = 0; d < 4; d++)
        begin
            slow <= d[0];
            u_ctrl.send_line($sformatf("D%0d\r", d), 1'b0);
            tick(2);
            check("term", cfg.term, d[1:0]);
            conv(rds[d]);
            ex = {rstr[d], "\r"};
            if (d < 2)
                ex = {ex, "\n"};
            expect_msg("reading", ex, d[0]);
        end
        slow <= 1'b0;
        u_ctrl.send_line("D0\r", 1'b0);
        $display("t_term done");
    endtask

    task automatic t_hold();
        u_ctrl.send_line("S\r", 1'b0);
        tick(40);
        u_ctrl.got.delete();
        check("hold", cfg.hold, 1);
        conv(rds[1]);
        tick(40);
        check("hold quiet", u_ctrl.got.size(), 0);
        check("hold display", display, rds[3]);
        u_ctrl.send_line("S\r", 1'b0);
        expect_msg("trigger", {rstr[1], "\r\n"}, 1'b0);
        check("trig display", display, rds[1]);
        u_ctrl.send_line("T\r", 1'b0);
        conv(rds[0]);
        expect_msg("track", {rstr[0], "\r\n"}, 1'b0);
        $display("t_hold done");
    endtask

    task automatic t_status();
        reg_write(REG_COND, 8'h05);
        reg_read(REG_COND, 8'h05, "cond reg");
        u_ctrl.send_line("E\r", 1'b0);
        conv(rds[2]);
        expect_msg("status", {"Q1V1I3TND0C0U F\r\n", rstr[2], "\r\n"}, 1'b0);
        $display("t_status done");
    endtask

    task automatic t_bad();
        u_ctrl.send_line("X\r", 1'b0);
        tick(3);
        check("srq", srq, 1);
        check("cfg kept", cfg, CFG_B);
        check("poll byte", spoll_byte, 8'h41);
        spoll_pulse();
        check("srq clear", srq, 0);
        u_ctrl.send_line("V7\r", 1'b0);
        tick(3);
        check("srq digit", srq, 1);
        check("volt kept", cfg.volt, 2'h1);
        spoll_pulse();
        u_ctrl.send_line("L\r", 1'b0);
        tick(3);
        check("local", remote, 0);
        $display("t_bad done");
    endtask

    task automatic print_verdict();
        $display("Checks %0d, errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        rds[0] = {1'b0, 1'b0, 20'h10567, 1'b0, 4'h4};
        rds[1] = {1'b1, 1'b0, 20'h19095, 1'b1, 4'h3};
        rds[2] = {1'b1, 1'b1, 20'h12345, 1'b1, 4'h2};
        rds[3] = {1'b0, 1'b0, 20'h99999, 1'b0, 4'h0};
        rstr[0] = "+1.0567E+4";
        rstr[1] = "-1.9095E-3";
        rstr[2] = "+2.0000E-2";
        rstr[3] = "+9.9999E+0";
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        t_local();
        t_remote();
        t_term();
        t_hold();
        t_status();
        t_bad();
        print_verdict();
    end

    // Whole run needs a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
